// File: logic/cgen_pkg.sv
// Constants, types and helpers shared by the clock generator files.
package cgen_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] CGEN_SEL_ADDR     = 16'hfffb;
    localparam logic [7:0]  CGEN_SEL_RESET    = 8'h02;
    localparam int          CGEN_DIV_BIT      = 1;
    localparam logic [2:0]  CGEN_DIV_BIT_IDX  = 3'h1;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CGEN_STAB_LOG2_XTAL = 15;
    localparam int          CGEN_STAB_LOG2_RC   = 7;
    localparam logic [1:0]  CGEN_SLOW_LAST      = 2'h3;
    localparam logic [1:0]  CGEN_SLOW_FIRST     = 2'h0;
    localparam int          CGEN_PDIV_W         = 8;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_STAB,
        ST_RUN,
        ST_HALT,
        ST_STOP
    } cgen_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        byte_wr;
        logic        bit_wr;
        logic [2:0]  bit_sel;
        logic        bit_val;
        logic [7:0]  wdata;
        logic        rd;
    } cgen_reg_req_t;

    typedef struct packed {
        logic halt;
        logic stop;
        logic wake;
    } cgen_standby_req_t;

    // Register image as software sees it; all other bits read zero.
    function automatic logic [7:0] cgen_image(input logic sel);
        cgen_image = 8'h00;
        cgen_image[CGEN_DIV_BIT] = sel;
    endfunction

endpackage

// File: logic/cgen_stab_timer.sv
// Oscillation stabilization timer counting 2^LOG2 running clock periods.
`timescale 1ns/1ns
module cgen_stab_timer
    import cgen_pkg::*;
#(
    parameter int LOG2 = CGEN_STAB_LOG2_XTAL
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    // Control
    input  wire logic start,
    input  wire logic run,
    // Status
    output logic      busy_q,
    output logic      done_q
);

    logic [LOG2-1:0] cnt_q;
    wire             last = busy_q && run && (cnt_q == {LOG2{1'b1}});

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= last;
            if (start) begin
                cnt_q  <= '0;
                busy_q <= 1'b1;
            end else if (last) begin
                busy_q <= 1'b0;
            end else if (busy_q && run) begin
                cnt_q  <= cnt_q + 1'b1;
            end
        end
    end

endmodule // cgen_stab_timer

// File: logic/cgen_clock_generator.sv
// CPU and peripheral clock generator with standby and stabilization control.
//
// Operation
// - Reset loads the selector with 02h, the slow quarter-rate CPU clock.
// - The oscillator stays stopped while reset is asserted.
// - Selector bit 1: 0 gives the undivided clock, 1 gives one quarter.
// - The shortest instruction spans two CPU clock periods.
// - Old clock persists after a change: at most 4 (fast) or 2 (slow) clocks.
// - Peripheral clocks divide the system clock and stop with it.
// - After reset release the oscillator starts and a 2^15 (or 2^7) wait runs.
// - When the wait ends the CPU starts running in slow mode.
// - The STOP standby instruction stops the oscillator.
// - Two standby states, STOP and HALT, are entered by CPU request.
// - The selector register accepts single-bit and byte-wide writes.
`timescale 1ns/1ns
module cgen_clock_generator
    import cgen_pkg::*;
#(
    parameter int STAB_LOG2 = CGEN_STAB_LOG2_XTAL,
    parameter int PDIV_W    = CGEN_PDIV_W
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset,
    // Register access from the CPU
    input  wire cgen_reg_req_t     reg_req,
    output logic [7:0]             reg_rdata_q,
    // Standby requests from the CPU
    input  wire cgen_standby_req_t standby,
    // Clock enables and status
    output logic                   osc_run_q,
    output logic                   cpu_clk_en_q,
    output logic                   instr_en_q,
    output logic                   cpu_run_q,
    output logic                   cpu_clk_slow_q,
    output logic [PDIV_W-1:0]      periph_clk_en_q
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    cgen_state_t       state_q;
    cgen_state_t       state_d;
    logic              boot_q;
    logic              sel_q;
    logic              sel_applied_q;
    logic [1:0]        slow_cnt_q;
    logic              instr_ph_q;
    logic [PDIV_W-1:0] div_q;
    logic [PDIV_W-1:0] periph_tick;
    logic              stab_busy;
    logic              stab_done;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    wire addr_hit  = reg_req.addr == CGEN_SEL_ADDR;
    wire byte_hit  = addr_hit && reg_req.byte_wr;
    wire bit_hit   = addr_hit && reg_req.bit_wr
                     && (reg_req.bit_sel == CGEN_DIV_BIT_IDX);
    // Bits other than the selector are not stored, so they read zero.
    wire sel_d     = byte_hit ? reg_req.wdata[CGEN_DIV_BIT]
                   : bit_hit  ? reg_req.bit_val
                   : sel_q;
    wire [7:0] rdata_d = (reg_req.rd && addr_hit) ? cgen_image(sel_q)
                                                  : 8'h00;

    // ------------------------------------------------------------------
    // CPU clock enable and changeover
    // ------------------------------------------------------------------
    wire running    = (state_q == ST_RUN) && osc_run_q;
    wire slow_last  = slow_cnt_q == CGEN_SLOW_LAST;
    wire cpu_tick   = running && (!sel_applied_q || slow_last);
    wire boundary   = cpu_tick && instr_ph_q;
    // A pending selection waits in ST_RUN for the end of a two-clock instruction
    // in the old clock and applies at once in other states, which meets both
    // changeover limits and never cuts a CPU clock short.
    wire switch_now = (sel_q != sel_applied_q)
                      && (boundary || state_q != ST_RUN);

    // ------------------------------------------------------------------
    // Standby sequencing
    // ------------------------------------------------------------------
    wire stab_start = boot_q || (state_q == ST_STOP && standby.wake);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_STAB: begin
                if (stab_done) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (standby.stop) begin
                    state_d = ST_STOP;
                end else if (standby.halt) begin
                    state_d = ST_HALT;
                end
            end
            ST_HALT: begin
                if (standby.wake) begin
                    state_d = ST_RUN;
                end
            end
            ST_STOP: begin
                if (standby.wake) begin
                    state_d = ST_STAB;
                end
            end
            default: state_d = ST_STAB;
        endcase
    end

    // ------------------------------------------------------------------
    // Peripheral dividers
    // ------------------------------------------------------------------
    // Each stage is the carry of the one below, so bit i fires when the
    // low i+1 divider bits are all ones.
    always_comb begin
        periph_tick    = '0;
        periph_tick[0] = osc_run_q && div_q[0];
        for (int i = 1; i < PDIV_W; i++) begin
            periph_tick[i] = periph_tick[i-1] && div_q[i];
        end
    end

    cgen_stab_timer #(
        .LOG2    (STAB_LOG2)
    ) cgen_stab_timer_inst (
        .ref_clk (ref_clk),
        .reset   (reset),
        .start   (stab_start),
        .run     (osc_run_q),
        .busy_q  (stab_busy),
        .done_q  (stab_done)
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q   <= ST_STAB;
            boot_q    <= 1'b1;
            osc_run_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            boot_q    <= 1'b0;
            osc_run_q <= (state_d != ST_STOP);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sel_q         <= CGEN_SEL_RESET[CGEN_DIV_BIT];
            sel_applied_q <= CGEN_SEL_RESET[CGEN_DIV_BIT];
            reg_rdata_q   <= 8'h00;
        end else begin
            sel_q       <= sel_d;
            reg_rdata_q <= rdata_d;
            if (switch_now) begin
                sel_applied_q <= sel_q;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || switch_now) begin
            slow_cnt_q <= CGEN_SLOW_FIRST;
        end else if (osc_run_q) begin
            slow_cnt_q <= slow_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || state_q != ST_RUN) begin
            instr_ph_q <= 1'b0;
        end else if (cpu_tick) begin
            instr_ph_q <= !instr_ph_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            div_q           <= '0;
            cpu_clk_en_q    <= 1'b0;
            instr_en_q      <= 1'b0;
            cpu_run_q       <= 1'b0;
            cpu_clk_slow_q  <= 1'b1;
            periph_clk_en_q <= '0;
        end else begin
            if (osc_run_q) begin
                div_q <= div_q + 1'b1;
            end
            cpu_clk_en_q    <= cpu_tick;
            instr_en_q      <= boundary;
            cpu_run_q       <= (state_q == ST_RUN);
            cpu_clk_slow_q  <= sel_applied_q;
            periph_clk_en_q <= periph_tick;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [31:0] wait_cnt_q;
    wire  [31:0] stab_cycles = 32'h1 << STAB_LOG2;

    always_ff @(posedge ref_clk) begin
        if (reset || stab_start) begin
            wait_cnt_q <= '0;
        end else if (stab_busy && osc_run_q) begin
            wait_cnt_q <= wait_cnt_q + 32'h1;
        end
    end

    a_reset_slow: assert property (@(posedge ref_clk)
        reset |=> sel_q && sel_applied_q && cpu_clk_slow_q)
        else $error("selector not slow after reset");
    a_osc_reset: assert property (@(posedge ref_clk)
        reset |=> !osc_run_q && !cpu_clk_en_q)
        else $error("oscillator running during reset");
    a_fast_tick: assert property (@(posedge ref_clk)
        disable iff (reset)
        (running && !sel_applied_q) |=> cpu_clk_en_q)
        else $error("fast clock missed a period");
    a_slow_gap: assert property (@(posedge ref_clk)
        disable iff (reset)
        (cpu_tick && sel_applied_q && !switch_now) |=> !cpu_tick [*3])
        else $error("slow clock period shorter than four");
    a_instr_slow: assert property (@(posedge ref_clk)
        disable iff (reset)
        (instr_en_q && cpu_clk_slow_q && !$past(switch_now))
        |=> !instr_en_q [*7])
        else $error("slow instruction shorter than two clocks");
    // Software may withdraw a selection before the boundary; the request
    // is then settled without any changeover.
    a_switch_fast: assert property (@(posedge ref_clk)
        disable iff (reset)
        (running && sel_q && !sel_applied_q)
        |-> ##[1:3] (sel_applied_q == sel_q || !running))
        else $error("fast to slow change too late");
    a_switch_slow: assert property (@(posedge ref_clk)
        disable iff (reset)
        (running && !sel_q && sel_applied_q)
        |-> ##[1:9] (sel_applied_q == sel_q || !running))
        else $error("slow to fast change too late");
    a_periph_halt: assert property (@(posedge ref_clk)
        disable iff (reset)
        !osc_run_q |=> periph_clk_en_q == '0)
        else $error("peripheral clock without oscillator");
    a_stab_len: assert property (@(posedge ref_clk)
        disable iff (reset)
        stab_done |-> wait_cnt_q == stab_cycles)
        else $error("stabilization wait has wrong length");
    a_run_after: assert property (@(posedge ref_clk)
        disable iff (reset)
        (state_q == ST_STAB && stab_done) |=> ##1 cpu_run_q)
        else $error("CPU not released after wait");
    a_stop_osc: assert property (@(posedge ref_clk)
        disable iff (reset)
        (state_q == ST_RUN && standby.stop) |=> !osc_run_q && !cpu_tick)
        else $error("oscillator still running in stop");
    a_halt_gate: assert property (@(posedge ref_clk)
        disable iff (reset)
        (state_q == ST_HALT) |-> osc_run_q && !cpu_tick)
        else $error("CPU clock running in halt");
    a_bit_write: assert property (@(posedge ref_clk)
        disable iff (reset)
        (bit_hit && !byte_hit) |=> sel_q == $past(reg_req.bit_val))
        else $error("bit write not stored");

    c_to_fast: cover property (@(posedge ref_clk) disable iff (reset)
        $fell(sel_applied_q) && running);
    c_stop_wake: cover property (@(posedge ref_clk) disable iff (reset)
        (state_q == ST_STOP) ##1 (state_q == ST_STAB));
    c_halt_wake: cover property (@(posedge ref_clk) disable iff (reset)
        (state_q == ST_HALT) ##1 (state_q == ST_RUN));

endmodule // cgen_clock_generator

// File: bench/cgen_cpu_model.sv
// Behavioural CPU core model: counts CPU clock pulses, issues standby requests.
`timescale 1ns/1ns
module cgen_cpu_model
    import cgen_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // Clock enable from the generator
    input  wire logic        cpu_clk_en,
    // Standby requests towards the generator
    output cgen_standby_req_t standby
);
    int pulses;

    initial standby = '0;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pulses <= 0;
        end else if (cpu_clk_en) begin
            pulses <= pulses + 1;
        end
    end

    // A request is a single-cycle pulse, as a standby instruction would give.
    task automatic request(input logic h, input logic s, input logic w);
        @(posedge ref_clk);
        standby <= '{halt: h, stop: s, wake: w};
        @(posedge ref_clk);
        standby <= '0;
        #1;
    endtask
endmodule // cgen_cpu_model

// File: bench/cgen_clock_generator_tb_top.sv
// Self-checking testbench for the clock generator.
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, a, b); end end
`define WAITC(c, n) begin for (int k = 0; k < (n) && !(c); k++) begin \
    @(posedge ref_clk); #1; end if (!(c)) begin err_total++; \
    $display("unexpected at %0t: timeout", $time); finish_test(); end end
module cgen_clock_generator_tb_top;
    import cgen_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int       STAB = 4;
    logic                ref_clk;
    logic                reset;
    cgen_reg_req_t       reg_req;
    logic [7:0]          reg_rdata_q;
    cgen_standby_req_t   standby;
    logic                osc_run_q;
    logic                cpu_clk_en_q;
    logic                instr_en_q;
    logic                cpu_run_q;
    logic                cpu_clk_slow_q;
    logic [CGEN_PDIV_W-1:0] periph_clk_en_q;
    int                  err_total = 0;
    int                  checks = 0;
    int                  n;

    cgen_clock_generator #(.STAB_LOG2(STAB)) cgen_clock_generator_inst (
        .ref_clk(ref_clk), .reset(reset), .reg_req(reg_req),
        .reg_rdata_q(reg_rdata_q), .standby(standby),
        .osc_run_q(osc_run_q), .cpu_clk_en_q(cpu_clk_en_q),
        .instr_en_q(instr_en_q), .cpu_run_q(cpu_run_q),
        .cpu_clk_slow_q(cpu_clk_slow_q), .periph_clk_en_q(periph_clk_en_q));
    cgen_cpu_model cgen_cpu_model_inst (
        .ref_clk(ref_clk), .reset(reset), .cpu_clk_en(cpu_clk_en_q),
        .standby(standby));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // One-cycle register access; read data is valid right after it.
    task automatic reg_op(input logic [15:0] a, input logic bw,
                          input logic bt, input logic rd,
                          input logic [2:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= '{addr: a, byte_wr: bw, bit_wr: bt, bit_sel: idx,
                     bit_val: d[0], wdata: d, rd: rd};
        @(posedge ref_clk);
        reg_req <= '0;
        #1;
    endtask

    // Cycles between two pulses of the CPU clock or instruction strobe.
    task automatic gap(input logic instr, output int g);
        `WAITC((instr ? instr_en_q : cpu_clk_en_q), 20)
        g = 0;
        do begin
            @(posedge ref_clk);
            #1;
            g++;
        end while (!(instr ? instr_en_q : cpu_clk_en_q) && g < 20);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        `CHK(osc_run_q, 1'b0)
        `CHK(cpu_clk_slow_q, 1'b1)
        reset <= 1'b0;
        repeat (1 << STAB) @(posedge ref_clk);
        #1;
        `CHK(osc_run_q, 1'b1)
        `CHK(cpu_run_q, 1'b0)
        `WAITC(cpu_run_q, 8)
        `CHK(cpu_clk_slow_q, 1'b1)
        reg_op(CGEN_SEL_ADDR, 0, 0, 1, 3'h0, 8'h00);
        `CHK(reg_rdata_q, CGEN_SEL_RESET)
    endtask

    task automatic t_rate();
        gap(1'b0, n);
        `CHK(n, 4)
        gap(1'b1, n);
        `CHK(n, 8)
    endtask

    task automatic t_regs();
        reg_op(CGEN_SEL_ADDR, 0, 1, 0, CGEN_DIV_BIT_IDX, 8'h01);
        reg_op(CGEN_SEL_ADDR, 0, 0, 1, 3'h0, 8'h00);
        `CHK(reg_rdata_q, 8'h02)
        reg_op(CGEN_SEL_ADDR, 0, 1, 0, 3'h0, 8'h00);
        reg_op(CGEN_SEL_ADDR, 1, 0, 0, 3'h0, 8'h00);
        reg_op(CGEN_SEL_ADDR, 0, 0, 1, 3'h0, 8'h00);
        `CHK(reg_rdata_q, 8'h00)
        reg_op(CGEN_SEL_ADDR, 1, 0, 0, 3'h0, 8'h02);
        reg_op(16'hfffa, 0, 0, 1, 3'h0, 8'h00);
        `CHK(reg_rdata_q, 8'h00)
        reg_op(CGEN_SEL_ADDR, 0, 0, 1, 3'h0, 8'h00);
        `CHK(reg_rdata_q, 8'h02)
    endtask

    task automatic t_switch();
        reg_op(CGEN_SEL_ADDR, 1, 0, 0, 3'h0, 8'h00);
        n = 0;
        while (cpu_clk_slow_q !== 1'b0 && n < 20) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        `CHK(n <= 9, 1'b1)
        gap(1'b0, n);
        `CHK(n, 1)
        reg_op(CGEN_SEL_ADDR, 0, 1, 0, CGEN_DIV_BIT_IDX, 8'h01);
        `WAITC(cpu_clk_slow_q, 3)
        gap(1'b0, n);
        `CHK(n, 4)
    endtask

    task automatic t_standby();
        logic seen;
        int   p0;
        cgen_cpu_model_inst.request(1'b1, 1'b0, 1'b0);
        // A CPU clock launched in the last run cycle still lands.
        @(posedge ref_clk);
        #1;
        n = cgen_cpu_model_inst.pulses;
        seen = 1'b0;
        p0 = 0;
        repeat (16) begin
            @(posedge ref_clk);
            #1;
            seen |= |periph_clk_en_q;
            p0 += periph_clk_en_q[0];
        end
        `CHK(cgen_cpu_model_inst.pulses, n)
        `CHK(seen, 1'b1)
        `CHK(p0, 8)
        cgen_cpu_model_inst.request(1'b0, 1'b0, 1'b1);
        `WAITC(cpu_run_q, 2)
        cgen_cpu_model_inst.request(1'b1, 1'b1, 1'b0);
        `CHK(osc_run_q, 1'b0)
        seen = 1'b0;
        repeat (16) begin
            @(posedge ref_clk);
            #1;
            seen |= |periph_clk_en_q;
        end
        `CHK(seen, 1'b0)
        cgen_cpu_model_inst.request(1'b0, 1'b0, 1'b1);
        `WAITC(osc_run_q, 2)
        `CHK(cpu_run_q, 1'b0)
        `WAITC(cpu_run_q, (1 << STAB) + 8)
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        reset = 1'b1;
        reg_req = '0;
        repeat (5) @(posedge ref_clk);
        #1;
        t_reset();
        t_rate();
        t_regs();
        t_switch();
        t_standby();
        finish_test();
    end
endmodule // cgen_clock_generator_tb_top
